// ===== hdl/hpc_regs.sv
// register bank, line normalisation, trigger and strobe logic of the parallel port card
`timescale 1ns/1ns
// How it works
// R1: mask register enables five interrupt sources
// R2: pending register bits 7,6,5,4,1; others zero
// R3: line-drive write sets controls and resets
// R4: falling reset output resets the peripheral
// R5: sense reads raw controls, normalised inputs
// R6: per-line polarity bit, one inverts
// R7: per-port data polarity bit, one inverts
// R8: flag edge select, default ready-to-busy
// R9: bits 7:6 select handshake type; here they are only stored and read back, no logic decodes them
// R10: trigger compare selects greater, equal, less
// R11: bit 4 strobes control on trigger
// R12: strobe count bits 6:0, bit 7 unit
// R13: trigger value compared with received characters
// R14: port output enables gated by switch 4
// R15: inhibit bit suppresses data output
// R16: terminator count plus seven terminator characters
// R17: abort ends transfer, controls false, ports off
// R18: halt stops transfer, lines keep state
// R19: reset enters power-on state
// R20: odd count in word transfer reports 113
// R21: handshake start with control true reports 116
// R22: status zero true aborts fast transfer, 114
// R23: trigger mode starts on compare match
// R24: inhibit uses status zero or one
// R25: interrupt when pending and mask both set
// R26: strobe length is count times unit
module hpc_regs #(
  parameter int COARSE_UNIT = hpc_pkg::COARSE_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire hpc_pkg::hpc_req_type i_req,
  input wire logic [7:0] i_line_in,
  input wire logic i_parity_err,
  input wire logic i_switch_oe,
  input wire logic i_abort,
  input wire logic i_halt,
  input wire logic i_start,
  input wire logic i_fast,
  input wire logic i_word_mode,
  input wire logic i_odd_count,
  input wire logic i_use_b,
  input wire logic i_trig_mode,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_periph_ready,
  output logic o_tx_ready,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic [3:0] o_ctrl_out,
  output logic o_periph_rst_line_a,
  output logic o_periph_rst_line_b,
  output logic [7:0] o_port_a_out,
  output logic o_port_a_oe,
  output logic [7:0] o_port_b_out,
  output logic o_port_b_oe,
  output logic o_ports_cd_on,
  output logic o_direction_ind_a,
  output logic o_direction_ind_b,
  output logic o_irq,
  output logic o_xfer_active,
  output logic o_trigger_hit,
  output logic [7:0] o_error,
  output logic [7:0] o_term_count,
  output logic [63:0] o_term_chars
);
  logic [7:0] intr_enable_mask;
  logic [7:0] intr_pending;
  logic [7:0] line_drive;
  logic [7:0] line_polarity;
  logic [7:0] handshake_config;
  logic [7:0] trigger_compare_cfg;
  logic [7:0] strobe_width;
  logic [7:0] trigger_value;
  logic [7:0] port_out_enable;
  logic [7:0] output_inhibit;
  logic [7:0] term_char [hpc_pkg::TERM_CHARS];
  logic [7:0] line_norm;
  logic [7:0] line_prev;
  logic [7:0] event_set;
  logic wr_intr;
  hpc_pkg::hpc_xfer_type xfer_state;
  hpc_pkg::hpc_word_type buf0;
  hpc_pkg::hpc_word_type buf1;
  logic match;
  logic [6:0] strobe_units;
  logic [19:0] strobe_tick;
  logic strobe_on;
  logic inhibit_now;
  logic [7:0] tx_norm;

  assign wr_intr = i_req.we && i_req.addr == hpc_pkg::ADDR_INTR;
  // inputs normalised by polarity; controls left raw
  assign line_norm = {i_line_in[7:4] ^ line_polarity[7:4], i_line_in[3:0]}; // R6
  // flag events on the chosen edge, status events on going true
  assign event_set[hpc_pkg::BIT_FLG_A] = handshake_config[hpc_pkg::BIT_FLAG_EDGE] ?
    (line_prev[4] && !line_norm[4]) : (!line_prev[4] && line_norm[4]); // R8
  assign event_set[hpc_pkg::BIT_FLG_B] = handshake_config[hpc_pkg::BIT_FLAG_EDGE] ?
    (line_prev[5] && !line_norm[5]) : (!line_prev[5] && line_norm[5]); // R8
  assign event_set[hpc_pkg::BIT_ST_0] = !line_prev[6] && line_norm[6];
  assign event_set[hpc_pkg::BIT_ST_1] = !line_prev[7] && line_norm[7];
  assign event_set[3:2] = 2'h0;
  assign event_set[hpc_pkg::BIT_PARITY] = i_parity_err;
  assign event_set[0] = 1'b0;
  assign match = (trigger_compare_cfg[hpc_pkg::BIT_GT] && i_rx_data > trigger_value)
    || (trigger_compare_cfg[hpc_pkg::BIT_EQ] && i_rx_data == trigger_value)
    || (trigger_compare_cfg[hpc_pkg::BIT_LT] && i_rx_data < trigger_value); // R10 R13
  assign inhibit_now = output_inhibit[hpc_pkg::BIT_INHIBIT]
    && (i_use_b ? line_norm[hpc_pkg::BIT_ST_1] : line_norm[hpc_pkg::BIT_ST_0]); // R15 R24

  always_ff @(posedge i_core_clk) begin
    // follows the lines through reset, so a line already true at release gives no false event
    if (!i_rst_n) begin
      line_prev <= line_norm;
    end else begin
      line_prev <= line_norm;
    end
  end

  // control register writes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin // R19
      intr_enable_mask <= hpc_pkg::RESET_VALUE;
      line_polarity <= hpc_pkg::RESET_VALUE;
      handshake_config <= hpc_pkg::RESET_VALUE; // R8
      trigger_compare_cfg <= hpc_pkg::RESET_VALUE;
      strobe_width <= hpc_pkg::RESET_VALUE;
      trigger_value <= hpc_pkg::RESET_VALUE;
      output_inhibit <= hpc_pkg::RESET_VALUE;
      o_term_count <= hpc_pkg::RESET_VALUE;
    end else if (i_req.we) begin
      case (i_req.addr)
        hpc_pkg::ADDR_INTR: intr_enable_mask <= i_req.wdata & hpc_pkg::INTR_MASK_BITS; // R1
        hpc_pkg::ADDR_POL: line_polarity <= i_req.wdata; // R6
        hpc_pkg::ADDR_HSCFG: handshake_config <= i_req.wdata; // R7 R9
        hpc_pkg::ADDR_TRIG_CFG: trigger_compare_cfg <= i_req.wdata; // R10 R11
        hpc_pkg::ADDR_STROBE: strobe_width <= i_req.wdata; // R12
        hpc_pkg::ADDR_TRIG_VAL: trigger_value <= i_req.wdata; // R13
        hpc_pkg::ADDR_INHIBIT: output_inhibit <= i_req.wdata; // R15
        hpc_pkg::ADDR_TERM_CNT: o_term_count <= i_req.wdata; // R16
        default: begin
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < hpc_pkg::TERM_CHARS; gi++) begin : g_term
      always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
          term_char[gi] <= hpc_pkg::RESET_VALUE;
        end else if (i_req.we && i_req.addr == hpc_pkg::ADDR_TERM_FIRST + 5'(gi)) begin
          term_char[gi] <= i_req.wdata; // R16
        end
      end
      assign o_term_chars[gi*8 +: 8] = term_char[gi];
    end
  endgenerate
  assign o_term_chars[63:56] = 8'h00;

  // pending flags: a new event wins over the read clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      intr_pending <= hpc_pkg::RESET_VALUE;
    end else if (i_req.re && i_req.addr == hpc_pkg::ADDR_INTR) begin
      intr_pending <= event_set & hpc_pkg::INTR_MASK_BITS; // R2
    end else begin
      intr_pending <= (intr_pending | event_set) & hpc_pkg::INTR_MASK_BITS; // R2
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(intr_pending & intr_enable_mask); // R25
    end
  end

  // line drive, abort forces controls false, strobe on trigger
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      line_drive <= 8'hC0; // R19
    end else if (i_abort) begin
      line_drive <= {line_drive[7:6], 6'h00}; // R17
    end else if (i_req.we && i_req.addr == hpc_pkg::ADDR_LINE) begin
      line_drive <= i_req.wdata; // R3
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_ctrl_out <= 4'h0;
      o_periph_rst_line_a <= 1'b1;
      o_periph_rst_line_b <= 1'b1;
    end else begin
      o_ctrl_out <= (line_drive[3:0] | {3'h0, strobe_on}) ^ line_polarity[3:0]; // R3 R6 R11
      o_periph_rst_line_a <= line_drive[hpc_pkg::BIT_RST_A]; // R4
      o_periph_rst_line_b <= line_drive[hpc_pkg::BIT_RST_B]; // R4
    end
  end

  // strobe timer: count times unit cycles
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_abort) begin
      strobe_on <= 1'b0;
      strobe_units <= 7'h00;
      strobe_tick <= 20'h00000;
    end else if (o_trigger_hit && trigger_compare_cfg[hpc_pkg::BIT_CTL_ON_TRIG]) begin
      strobe_on <= 1'b1; // R11
      strobe_units <= (strobe_width[6:0] == 7'h00) ? 7'h01 : strobe_width[6:0];
      strobe_tick <= strobe_width[hpc_pkg::BIT_UNIT] ? 20'(COARSE_UNIT - 1) : 20'(hpc_pkg::FINE_CYCLES - 1);
    end else if (strobe_on) begin
      if (strobe_tick != 20'h00000) begin
        strobe_tick <= strobe_tick - 20'h00001; // R26
      end else if (strobe_units == 7'h01) begin
        strobe_on <= 1'b0;
      end else begin
        strobe_units <= strobe_units - 7'h01;
        strobe_tick <= strobe_width[hpc_pkg::BIT_UNIT] ? 20'(COARSE_UNIT - 1) : 20'(hpc_pkg::FINE_CYCLES - 1); // R12
      end
    end
  end

  // transfer state and errors
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_abort || i_halt) begin
      xfer_state <= hpc_pkg::XS_IDLE; // R17 R18
      o_xfer_active <= 1'b0;
      o_trigger_hit <= 1'b0;
    end else begin
      o_trigger_hit <= 1'b0;
      case (xfer_state)
        hpc_pkg::XS_IDLE: begin
          if (i_start && line_drive[hpc_pkg::BIT_CTL_A] == 1'b0) begin // R21
            xfer_state <= i_trig_mode ? hpc_pkg::XS_WAIT_TRIG : hpc_pkg::XS_RUN;
            o_xfer_active <= !i_trig_mode;
          end
        end
        hpc_pkg::XS_WAIT_TRIG: begin
          if (i_rx_valid && match) begin // R23
            xfer_state <= hpc_pkg::XS_RUN;
            o_xfer_active <= 1'b1;
            o_trigger_hit <= 1'b1;
          end
        end
        hpc_pkg::XS_RUN: begin
          if (i_fast && line_norm[hpc_pkg::BIT_ST_0]) begin // R22
            xfer_state <= hpc_pkg::XS_IDLE;
            o_xfer_active <= 1'b0;
          end
        end
        default: xfer_state <= hpc_pkg::XS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_error <= hpc_pkg::ERR_NONE;
    end else if (i_start && line_drive[hpc_pkg::BIT_CTL_A]) begin
      o_error <= hpc_pkg::ERR_CTL_BUSY; // R21
    end else if (xfer_state == hpc_pkg::XS_RUN && i_fast && line_norm[hpc_pkg::BIT_ST_0]) begin
      o_error <= hpc_pkg::ERR_FHS_ABORT; // R22
    end else if (i_start && i_word_mode && i_odd_count) begin
      o_error <= hpc_pkg::ERR_SPLIT_WORD; // R20
    end else if (i_req.we && i_req.addr == hpc_pkg::ADDR_PORT_OE && !i_switch_oe) begin
      o_error <= hpc_pkg::ERR_OUT_DENIED; // R14
    end else if (i_tx_valid && !(i_use_b ? port_out_enable[hpc_pkg::BIT_OE_B] : port_out_enable[hpc_pkg::BIT_OE_A])) begin
      o_error <= hpc_pkg::ERR_OUT_DENIED; // R14
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      port_out_enable <= hpc_pkg::RESET_VALUE;
    end else if (i_abort) begin
      port_out_enable <= hpc_pkg::RESET_VALUE; // R17
    end else if (i_req.we && i_req.addr == hpc_pkg::ADDR_PORT_OE && i_switch_oe) begin
      port_out_enable <= i_req.wdata; // R14
    end
  end

  // two-entry output buffer; drains only when peripheral ready and not inhibited
  assign o_tx_ready = !buf1.valid;
  assign tx_norm = i_tx_data ^ {8{i_use_b ? handshake_config[2] : handshake_config[1]}}; // R7
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_abort) begin
      buf0 <= '0;
      buf1 <= '0;
    end else begin
      if (buf0.valid && i_periph_ready && !inhibit_now && !i_halt) begin // R15 R18
        buf0 <= buf1.valid ? buf1 : (i_tx_valid ? {1'b1, tx_norm} : '0);
        // a full second entry holds ready low, so no new word is taken in this cycle
        buf1 <= '0;
      end else if (i_tx_valid && o_tx_ready) begin
        if (!buf0.valid) buf0 <= {1'b1, tx_norm};
        else buf1 <= {1'b1, tx_norm};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_abort) begin
      o_port_a_oe <= 1'b0; // R17 R19
      o_port_b_oe <= 1'b0;
      o_ports_cd_on <= 1'b0;
      o_port_a_out <= 8'h00;
      o_port_b_out <= 8'h00;
      o_direction_ind_a <= 1'b1;
      o_direction_ind_b <= 1'b1;
    end else begin
      o_port_a_oe <= port_out_enable[hpc_pkg::BIT_OE_A] && !inhibit_now; // R14 R15
      o_port_b_oe <= port_out_enable[hpc_pkg::BIT_OE_B] && !inhibit_now;
      o_ports_cd_on <= o_xfer_active;
      if (buf0.valid && i_periph_ready && !inhibit_now && !i_halt) begin
        if (i_use_b) o_port_b_out <= buf0.data;
        else o_port_a_out <= buf0.data;
      end
    end
  end

  // register reads, answered one cycle later
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_rd_valid <= i_req.re;
      case (i_req.addr)
        hpc_pkg::ADDR_INTR: o_rd_data <= intr_pending; // R2
        hpc_pkg::ADDR_LINE: o_rd_data <= {line_norm[7:4], line_drive[3:0]}; // R5
        hpc_pkg::ADDR_POL: o_rd_data <= line_polarity;
        hpc_pkg::ADDR_HSCFG: o_rd_data <= handshake_config;
        hpc_pkg::ADDR_TRIG_CFG: o_rd_data <= trigger_compare_cfg;
        hpc_pkg::ADDR_STROBE: o_rd_data <= strobe_width;
        hpc_pkg::ADDR_TRIG_VAL: o_rd_data <= trigger_value;
        hpc_pkg::ADDR_PORT_OE: o_rd_data <= port_out_enable;
        hpc_pkg::ADDR_INHIBIT: o_rd_data <= output_inhibit;
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  property p_irq_follows;
    @(posedge i_core_clk) disable iff (!i_rst_n) |(intr_pending & intr_enable_mask) |=> o_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing"); // R25
  property p_pend_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n) intr_pending[3:2] == 2'h0 && !intr_pending[0];
  endproperty
  a_pend_zero: assert property (p_pend_zero) else $error("reserved pending set"); // R2
  property p_abort_ports;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_abort |=> !o_port_a_oe && !o_port_b_oe && !o_ports_cd_on;
  endproperty
  a_abort_ports: assert property (p_abort_ports) else $error("abort left port on"); // R17
  property p_drive;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.we && i_req.addr == hpc_pkg::ADDR_LINE && !i_abort ##1 !i_abort
      |=> o_periph_rst_line_a == $past(i_req.wdata[6], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("reset line wrong"); // R3
  property p_oe_lock;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.we && i_req.addr == hpc_pkg::ADDR_PORT_OE && !i_switch_oe |=> o_error == hpc_pkg::ERR_OUT_DENIED
      || o_error == hpc_pkg::ERR_CTL_BUSY || o_error == hpc_pkg::ERR_FHS_ABORT || o_error == hpc_pkg::ERR_SPLIT_WORD;
  endproperty
  a_oe_lock: assert property (p_oe_lock) else $error("locked write not flagged"); // R14
  property p_ctl_busy;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_start && line_drive[0] |=> o_error == hpc_pkg::ERR_CTL_BUSY;
  endproperty
  a_ctl_busy: assert property (p_ctl_busy) else $error("116 not reported"); // R21
  property p_halt;
    @(posedge i_core_clk) disable iff (!i_rst_n) i_halt && !i_abort |=> $stable(o_ctrl_out) || $changed(line_drive);
  endproperty
  a_halt: assert property (p_halt) else $error("halt moved lines"); // R18
  property p_strobe_cnt;
    @(posedge i_core_clk) disable iff (!i_rst_n) strobe_on && strobe_tick != 20'h00000 && !i_abort |=> strobe_on;
  endproperty
  a_strobe_cnt: assert property (p_strobe_cnt) else $error("strobe ended early"); // R26
endmodule : hpc_regs

// ===== hdl/hpc_pkg.sv
// shared constants and types for the handshake port control register bank
package hpc_pkg;
  localparam logic [4:0] ADDR_INTR = 5'h01;
  localparam logic [4:0] ADDR_LINE = 5'h02;
  localparam logic [4:0] ADDR_POL = 5'h03;
  localparam logic [4:0] ADDR_HSCFG = 5'h04;
  localparam logic [4:0] ADDR_TRIG_CFG = 5'h05;
  localparam logic [4:0] ADDR_STROBE = 5'h06;
  localparam logic [4:0] ADDR_TRIG_VAL = 5'h07;
  localparam logic [4:0] ADDR_PORT_OE = 5'h08;
  localparam logic [4:0] ADDR_INHIBIT = 5'h09;
  localparam logic [4:0] ADDR_TERM_CNT = 5'h10;
  localparam logic [4:0] ADDR_TERM_FIRST = 5'h11;
  localparam logic [4:0] ADDR_TERM_LAST = 5'h17;
  localparam int TERM_CHARS = 7;
  // line bit positions shared by drive, sense and polarity registers
  localparam int BIT_CTL_A = 0;
  localparam int BIT_CTL_0 = 1;
  localparam int BIT_CTL_B = 2;
  localparam int BIT_CTL_1 = 3;
  localparam int BIT_FLG_A = 4;
  localparam int BIT_FLG_B = 5;
  localparam int BIT_ST_0 = 6;
  localparam int BIT_ST_1 = 7;
  localparam int BIT_RST_A = 6;
  localparam int BIT_RST_B = 7;
  localparam int BIT_PARITY = 1;
  localparam int BIT_FLAG_EDGE = 5;
  localparam int BIT_CTL_ON_TRIG = 4;
  localparam int BIT_GT = 7;
  localparam int BIT_EQ = 6;
  localparam int BIT_LT = 5;
  localparam int BIT_OE_A = 0;
  localparam int BIT_OE_B = 1;
  localparam int BIT_INHIBIT = 1;
  localparam int BIT_UNIT = 7;
  localparam logic [7:0] INTR_MASK_BITS = 8'hF2;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SPLIT_WORD = 8'h71;
  localparam logic [7:0] ERR_FHS_ABORT = 8'h72;
  localparam logic [7:0] ERR_OUT_DENIED = 8'h73;
  localparam logic [7:0] ERR_CTL_BUSY = 8'h74;
  // strobe time units
  localparam int CLK_NS = 100;
  localparam int UNIT_FINE_NS = 10000;
  localparam int UNIT_COARSE_NS = 1000000;
  localparam int FINE_CYCLES = UNIT_FINE_NS / CLK_NS;
  localparam int COARSE_CYCLES = UNIT_COARSE_NS / CLK_NS;
  typedef enum logic [1:0] {
    HS_FULL = 2'b00,
    HS_PARTIAL = 2'b01,
    HS_STROBE = 2'b10,
    HS_NONE = 2'b11
  } hpc_mode_type;
  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_WAIT_TRIG = 2'b01,
    XS_RUN = 2'b10
  } hpc_xfer_type;
  typedef struct packed {
    logic we;
    logic re;
    logic [4:0] addr;
    logic [7:0] wdata;
  } hpc_req_type;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hpc_word_type;
endpackage : hpc_pkg

// ===== dv/hpc_periph_model.sv
// peripheral model at the far side of the parallel ports
`timescale 1ns/1ns
module hpc_periph_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  input wire logic [3:0] i_lines,
  input wire logic i_rst_line_a,
  input wire logic i_rst_line_b,
  output logic [7:0] o_line_in,
  output logic o_periph_ready,
  output logic [7:0] o_reset_count
);
  logic [3:0] churn = 4'h0;
  logic prev_a = 1'b1;
  logic prev_b = 1'b1;
  // unused control inputs change every cycle so no stale level is relied upon
  assign o_line_in = {i_lines, churn};
  assign o_periph_ready = !i_stall;
  always @(posedge i_core_clk) begin
    churn <= churn + 4'h5;
    prev_a <= i_rst_line_a;
    prev_b <= i_rst_line_b;
    if (!i_rst_n) begin
      o_reset_count <= 8'h00;
    end else if ((prev_a && !i_rst_line_a) || (prev_b && !i_rst_line_b)) begin
      o_reset_count <= o_reset_count + 8'h01;
    end
  end
endmodule : hpc_periph_model

// ===== dv/hpc_regs_test.sv
// self-checking testbench of the handshake port control register bank
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
`define PULSE(s) begin @(negedge clk) s <= 1'b1; @(negedge clk) s <= 1'b0; end
module hpc_regs_test;
  typedef struct packed {
    logic [7:0] exp;
    logic [7:0] mask;
  } hpc_note_type;
  localparam int CU = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  hpc_pkg::hpc_req_type req = '0;
  logic par = 1'b0, sw_oe = 1'b1, abort = 1'b0, halt = 1'b0, start = 1'b0, fast = 1'b0;
  logic word = 1'b0, odd = 1'b0, trig = 1'b0, rx_v = 1'b0, tx_v = 1'b0, stall = 1'b0, hit = 1'b0;
  logic use_b = 1'b0;
  logic [7:0] rx_d = 8'h00, tx_d = 8'h00;
  logic [3:0] lines = 4'h0;
  logic [55:0] tc;
  logic [7:0] w[4];
  logic [7:0] hitc[3] = '{8'h41, 8'h40, 8'h3F};
  logic [7:0] missc[3] = '{8'h40, 8'h3F, 8'h40};
  logic [7:0] sw[3] = '{8'h03, 8'h82, 8'h01};
  int slen[3] = '{3 * hpc_pkg::FINE_CYCLES, 2 * CU, hpc_pkg::FINE_CYCLES};
  logic [4:0] ra[13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h10, 5'h11, 5'h17, 5'h1F};
  wire logic [7:0] line_in, rd_d, pa, pb, err, tcnt, rcnt;
  wire logic xact;
  wire logic [63:0] tchars;
  wire logic [3:0] ctl;
  wire logic tx_rdy, rd_v, rst_a, rst_b, pa_oe, pb_oe, cd_on, dir_a, dir_b, irq, thit, p_rdy;
  int failures = 0;
  int tests_run = 0;
  int k, i, len;
  hpc_note_type notes[$];
  hpc_note_type n;

  hpc_regs #(.COARSE_UNIT(CU)) hpc_regs_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_line_in(line_in), .i_parity_err(par),
    .i_switch_oe(sw_oe), .i_abort(abort), .i_halt(halt), .i_start(start), .i_fast(fast),
    .i_word_mode(word), .i_odd_count(odd), .i_use_b(use_b), .i_trig_mode(trig), .i_rx_valid(rx_v),
    .i_rx_data(rx_d), .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_periph_ready(p_rdy), .o_tx_ready(tx_rdy),
    .o_rd_valid(rd_v), .o_rd_data(rd_d), .o_ctrl_out(ctl), .o_periph_rst_line_a(rst_a),
    .o_periph_rst_line_b(rst_b), .o_port_a_out(pa), .o_port_a_oe(pa_oe), .o_port_b_out(pb),
    .o_port_b_oe(pb_oe), .o_ports_cd_on(cd_on), .o_direction_ind_a(dir_a), .o_direction_ind_b(dir_b),
    .o_irq(irq), .o_xfer_active(xact), .o_trigger_hit(thit), .o_error(err), .o_term_count(tcnt),
    .o_term_chars(tchars)
  );
  hpc_periph_model hpc_periph_model_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_lines(lines), .i_rst_line_a(rst_a),
    .i_rst_line_b(rst_b), .o_line_in(line_in), .o_periph_ready(p_rdy), .o_reset_count(rcnt)
  );

  always #50 clk = ~clk;

  function automatic logic [7:0] msk(input logic [4:0] a);
    case (a)
      5'h04: msk = 8'hFE;
      5'h05: msk = 8'hF0;
      5'h08: msk = 8'h03;
      5'h09: msk = 8'h02;
      default: msk = 8'hFF;
    endcase
  endfunction : msk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk) req <= '{1'b1, 1'b0, a, d};
    @(negedge clk) req <= '0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{e, m});
    @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req <= '0;
  endtask : rd

  task automatic ticks(input int c);
    repeat (c) @(negedge clk);
  endtask : ticks

  task automatic chk_err(input logic [7:0] e);
    for (int j = 0; j < 20 && err !== e; j++) @(negedge clk);
    `CHK(err, e)
  endtask : chk_err

  task automatic see(input logic [7:0] d);
    for (int j = 0; j < 50 && (use_b ? pb : pa) !== d; j++) @(negedge clk);
    `CHK(use_b ? pb : pa, d)
  endtask : see

  task automatic push(input logic [7:0] d);
    @(negedge clk);
    tx_v <= 1'b1;
    tx_d <= d;
    @(posedge clk);
    for (int j = 0; j < 200 && tx_rdy !== 1'b1; j++) @(posedge clk);
    @(negedge clk) tx_v <= 1'b0;
  endtask : push

  task automatic send(input logic [7:0] c);
    @(negedge clk);
    rx_v <= 1'b1;
    rx_d <= c;
    @(negedge clk) rx_v <= 1'b0;
  endtask : send

  task automatic print_verdict();
    $display("Checks made %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // read answers are matched against the oldest pending note
  always @(posedge clk) begin
    if (thit === 1'b1) hit <= 1'b1;
    if (rd_v === 1'b1) begin
      if (notes.size() == 0) begin
        failures++;
        $display("Error at %0t: read answer with nothing expected", $time);
      end else begin
        n = notes.pop_front();
        `CHK(rd_d & n.mask, n.exp & n.mask)
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(98));
    repeat (8) @(negedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK(ctl, 4'h0)
    `CHK({rst_a, rst_b, dir_a, dir_b, pa_oe, pb_oe, cd_on}, 7'h78)
    foreach (ra[j]) rd(ra[j], 8'h00, msk(ra[j]));
    for (k = 0; k < 4; k++) begin
      w[0] = {k[1:0], 6'($urandom)};
      wr(5'h04, w[0]);
      rd(5'h04, w[0], 8'hFE);
    end
    wr(5'h04, 8'h00);
    for (k = 3; k < 10; k++) begin
      if (k == 4) continue;
      w[0] = 8'($urandom);
      wr(5'(k), w[0]);
      rd(5'(k), w[0], msk(5'(k)));
      wr(5'(k), 8'h00);
    end
    sw_oe <= 1'b0;
    wr(5'h08, 8'h03);
    @(negedge clk);
    `CHK(err, hpc_pkg::ERR_OUT_DENIED)
    rd(5'h08, 8'h00, 8'h03);
    sw_oe <= 1'b1;
    wr(5'h03, 8'h30);
    lines <= 4'b0101;
    wr(5'h02, 8'h05);
    ticks(2);
    `CHK(ctl, 4'h5)
    `CHK({rst_a, rst_b, rcnt}, 10'h001)
    rd(5'h02, 8'h65, 8'hFF);
    wr(5'h03, 8'h01);
    ticks(2);
    `CHK(ctl, 4'h4)
    wr(5'h03, 8'h00);
    `PULSE(halt)
    ticks(3);
    `CHK(ctl, 4'h5)
    `PULSE(abort)
    ticks(3);
    `CHK({ctl, pa_oe, pb_oe, cd_on}, 7'h00)
    wr(5'h02, 8'hC1);
    `PULSE(start)
    chk_err(hpc_pkg::ERR_CTL_BUSY);
    wr(5'h02, 8'hC0);
    word <= 1'b1;
    odd <= 1'b1;
    `PULSE(start)
    chk_err(hpc_pkg::ERR_SPLIT_WORD);
    word <= 1'b0;
    odd <= 1'b0;
    `PULSE(abort)
    lines <= 4'h0;
    fast <= 1'b1;
    `PULSE(start)
    lines <= 4'h4;
    chk_err(hpc_pkg::ERR_FHS_ABORT);
    fast <= 1'b0;
    lines <= 4'h0;
    `PULSE(abort)
    rd(5'h01, 8'h00, 8'h00);
    wr(5'h01, 8'h02);
    `PULSE(par)
    ticks(3);
    `CHK(irq, 1'b1)
    rd(5'h01, 8'h02, 8'h0F);
    ticks(3);
    `CHK(irq, 1'b0)
    wr(5'h01, 8'hF0);
    `PULSE(par)
    ticks(3);
    `CHK(irq, 1'b0)
    rd(5'h01, 8'h02, 8'h0F);
    tc = 56'({$urandom, $urandom});
    wr(5'h10, 8'h07);
    for (k = 0; k < 7; k++) wr(5'(5'h11 + k), tc[8*k+:8]);
    ticks(1);
    `CHK(tcnt, 8'h07)
    `CHK(tchars, {8'h00, tc})
    wr(5'h08, 8'h01);
    stall <= 1'b1;
    for (k = 0; k < 4; k++) w[k] = {k[1:0], 1'b1, 5'($urandom)};
    push(w[0]);
    push(w[1]);
    @(negedge clk);
    `CHK(tx_rdy, 1'b0)
    stall <= 1'b0;
    see(w[0]);
    see(w[1]);
    `CHK(pa_oe, 1'b1)
    wr(5'h09, 8'h02);
    lines <= 4'h4;
    push(w[2]);
    ticks(20);
    `CHK(pa === w[2], 1'b0)
    wr(5'h09, 8'h00);
    lines <= 4'h0;
    see(w[2]);
    use_b <= 1'b1;
    wr(5'h08, 8'h02);
    wr(5'h04, 8'h04);
    push(~w[3]);
    see(w[3]);
    `CHK(pb_oe, 1'b1)
    use_b <= 1'b0;
    wr(5'h04, 8'h00);
    wr(5'h07, 8'h40);
    for (k = 0; k < 3; k++) begin
      wr(5'h06, sw[k]);
      wr(5'h05, 8'h10 | (8'h80 >> k));
      trig <= 1'b1;
      `PULSE(start)
      hit = 1'b0;
      send(missc[k]);
      ticks(6);
      `CHK(hit, 1'b0)
      `CHK(xact, 1'b0)
      send(hitc[k]);
      for (i = 0; i < 10 && hit !== 1'b1; i++) @(negedge clk);
      `CHK(hit, 1'b1)
      `CHK(xact, 1'b1)
      for (i = 0; i < 10 && ctl[0] !== 1'b1; i++) @(negedge clk);
      for (len = 0; len < 3000 && ctl[0] === 1'b1; len++) @(negedge clk);
      `CHK(len + 3 >= slen[k] && len <= slen[k] + 2, 1'b1)
      `PULSE(abort)
      trig <= 1'b0;
    end
    print_verdict();
  end
endmodule : hpc_regs_test
